/* include/sfc_pkg.sv */
package sfc_pkg;
  // =====================================================================
  // opcodes
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_RDSR1  = 8'h05;
  localparam logic [7:0] OP_RDSR2  = 8'h35;
  localparam logic [7:0] OP_RDSR3  = 8'h15;
  localparam logic [7:0] OP_WRSR1  = 8'h01;
  localparam logic [7:0] OP_WRSR2  = 8'h31;
  localparam logic [7:0] OP_WRSR3  = 8'h11;
  localparam logic [7:0] OP_READ   = 8'h03;
  localparam logic [7:0] OP_FREAD  = 8'h0B;
  localparam logic [7:0] OP_DOREAD = 8'h3B;
  localparam logic [7:0] OP_QOREAD = 8'h6B;
  localparam logic [7:0] OP_DIOREAD = 8'hBB;
  localparam logic [7:0] OP_QIOREAD = 8'hEB;
  localparam logic [7:0] OP_UID    = 8'h4B;
  localparam logic [7:0] OP_PP     = 8'h02;
  localparam logic [7:0] OP_QPP    = 8'h32;
  localparam logic [7:0] OP_SE     = 8'h20;
  localparam logic [7:0] OP_BE32   = 8'h52;
  localparam logic [7:0] OP_BE64   = 8'hD8;
  localparam logic [7:0] OP_CE1    = 8'hC7;
  localparam logic [7:0] OP_CE2    = 8'h60;
  localparam logic [7:0] OP_DPD    = 8'hB9;
  localparam logic [7:0] OP_RDPD   = 8'hAB;
  localparam logic [7:0] OP_PSR    = 8'h42;
  localparam logic [7:0] OP_ESR    = 8'h44;
  // =====================================================================
  // phase lengths in serial clocks
  localparam logic [5:0] N_ADDR    = 6'h18;
  localparam logic [5:0] N_DUMMY8  = 6'h08;
  localparam logic [5:0] N_DIO_LO  = 6'h04;
  localparam logic [5:0] N_DIO_HI  = 6'h08;
  localparam logic [5:0] N_QIO_LO  = 6'h06;
  localparam logic [5:0] N_QIO_HI  = 6'h0A;
  localparam logic [5:0] N_UID     = 6'h20;
  localparam logic [5:0] N_RDPD_ID = 6'h18;
  localparam logic [8:0] PAGE_MAX  = 9'h100;
  // status bit positions
  localparam int SB_LOCK1 = 11;
  localparam int SB_LOCK3 = 13;
  localparam int SB_CMP   = 14;
  localparam int SB_DC    = 16;
  localparam logic [23:0] STATUS_RESET = 24'h000000;
  // =====================================================================
  typedef enum logic [2:0] {
    SFC_K_NONE, SFC_K_PROG, SFC_K_ERASE, SFC_K_CHIP, SFC_K_WRSR, SFC_K_SEC_PROG, SFC_K_SEC_ERASE
  } sfc_kind_t;
  // command handed to the array engine
  typedef struct packed {
    sfc_kind_t   kind;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [8:0]  nbytes;
  } sfc_exec_t;
endpackage

/* src/sfc_frontend.sv */
`timescale 1ns/10ps
// What this block does
// - three lock bits reset to zero; each set to one by status write.
// - a set lock bit never clears; its security register refuses program and erase.
// - protect_complement held in status bit 14, reset zero, passed to protection.
// - dual I/O read inserts 4 dummy clocks, 8 when dummy_cycle_select set.
// - quad I/O read inserts 6 dummy clocks, 10 when dummy_cycle_select set.
// - bits sampled on rising serial clock, msb first, after select falls.
// - eight-bit opcode first, then address, data, both or nothing.
// - read commands stream output until the host raises select.
// - write-type commands execute only when clock count is multiple of eight.
// - partial page-program byte: no programming, write_latch_flag stays set.
// - dual-output read takes three address bytes and 8 dummy clocks.
// - quad-output read takes three address bytes and 8 dummy clocks.
// - unique-id read has 32 dummy clocks covering address time, then data.
// - mode_byte clocks of dual/quad I/O reads count as dummy clocks.
// - release opcode wakes; after 24 dummy clocks it outputs device id.
// - write_latch_flag zero refuses status writes, program and erase.
// - busy_flag one while program, erase or status write runs.
module sfc_frontend #(
  parameter int ADDR_BITS = 24
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              select_n,
  input  wire logic              serial_clk,
  input  wire logic              serial_in,
  input  wire logic              engine_done,
  output logic                   exec_valid,
  output sfc_pkg::sfc_exec_t     exec_cmd,
  output logic                   data_valid,
  output logic [7:0]             data_byte,
  output logic                   read_start,
  output logic [7:0]             read_opcode,
  output logic [ADDR_BITS-1:0]   read_addr,
  output logic                   read_active,
  output logic                   id_out_active,
  output logic                   deep_power_down,
  output logic [23:0]            status,
  output logic                   write_latch_flag,
  output logic                   busy_flag,
  output logic [2:0]             security_locks,
  output logic                   protect_complement,
  output logic                   dummy_cycle_select
);
  // =====================================================================
  // pin synchronisers
  logic [1:0] cs_sync;
  logic [1:0] ck_sync;
  logic [1:0] di_sync;
  logic       ck_prev;
  logic       cs_prev;

  // two flops per pin, then edge detection on the second stage only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cs_sync <= 2'h3;
      ck_sync <= 2'h0;
      di_sync <= 2'h0;
      ck_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], select_n};
      ck_sync <= {ck_sync[0], serial_clk};
      di_sync <= {di_sync[0], serial_in};
      ck_prev <= ck_sync[1];
      cs_prev <= cs_sync[1];
    end
  end

  logic cs_low;
  logic rise;
  logic cs_rise;
  logic din;
  assign cs_low  = ~cs_sync[1];
  assign rise    = cs_low & ck_sync[1] & ~ck_prev;
  assign cs_rise = cs_sync[1] & ~cs_prev;
  assign din     = di_sync[1];

  // =====================================================================
  // frame decoder
  typedef enum logic [2:0] {ST_OP, ST_ADDR, ST_DUMMY, ST_DATA, ST_OUT, ST_IGNORE} sfc_state_t;
  sfc_state_t state;
  logic [7:0]  opcode;
  logic [7:0]  shreg;
  logic [2:0]  bitcnt;
  logic [5:0]  phase_cnt;
  logic [23:0] addr;
  logic [8:0]  nbytes;
  logic        mid_byte;
  logic [7:0]  shifted;
  logic [23:0] next_addr;
  logic        has_addr;
  logic        is_read;
  logic [5:0]  dummy_len;
  logic [5:0]  dummy_len_q;
  logic        read_q;

  assign shifted   = {shreg[6:0], din};
  assign next_addr = {addr[22:0], din};

  // address and dummy needs of the opcode just received
  always_comb begin
    has_addr  = 1'b0;
    is_read   = 1'b0;
    dummy_len = 6'h00;
    unique case (shifted)
      sfc_pkg::OP_READ: begin
        has_addr = 1'b1;
        is_read  = 1'b1;
      end
      sfc_pkg::OP_FREAD, sfc_pkg::OP_DOREAD, sfc_pkg::OP_QOREAD: begin
        has_addr  = 1'b1;
        is_read   = 1'b1;
        dummy_len = sfc_pkg::N_DUMMY8;
      end
      sfc_pkg::OP_DIOREAD: begin
        has_addr  = 1'b1;
        is_read   = 1'b1;
        dummy_len = dummy_cycle_select ? sfc_pkg::N_DIO_HI : sfc_pkg::N_DIO_LO;
      end
      sfc_pkg::OP_QIOREAD: begin
        has_addr  = 1'b1;
        is_read   = 1'b1;
        dummy_len = dummy_cycle_select ? sfc_pkg::N_QIO_HI : sfc_pkg::N_QIO_LO;
      end
      sfc_pkg::OP_UID: begin
        is_read   = 1'b1;
        dummy_len = sfc_pkg::N_UID;
      end
      sfc_pkg::OP_RDSR1, sfc_pkg::OP_RDSR2, sfc_pkg::OP_RDSR3: is_read = 1'b1;
      sfc_pkg::OP_RDPD: is_read = 1'b1;
      sfc_pkg::OP_PP, sfc_pkg::OP_QPP, sfc_pkg::OP_SE, sfc_pkg::OP_BE32, sfc_pkg::OP_BE64,
      sfc_pkg::OP_PSR, sfc_pkg::OP_ESR: has_addr = 1'b1;
      default: begin
      end
    endcase
  end

  function automatic logic known_op(input logic [7:0] op);
    unique case (op)
      sfc_pkg::OP_WREN, sfc_pkg::OP_WRDI, sfc_pkg::OP_WRSR1, sfc_pkg::OP_WRSR2, sfc_pkg::OP_WRSR3,
      sfc_pkg::OP_CE1, sfc_pkg::OP_CE2, sfc_pkg::OP_DPD, sfc_pkg::OP_RDPD: known_op = 1'b1;
      default: known_op = 1'b0;
    endcase
  endfunction

  // serial sequencing of opcode, address, dummy, data and output phases
  always_ff @(posedge ref_clk) begin
    if (reset || !cs_low) begin
      state     <= ST_OP;
      bitcnt    <= 3'h0;
      phase_cnt <= 6'h00;
      shreg     <= 8'h00;
      if (reset) begin
        opcode   <= 8'h00;
        addr     <= 24'h000000;
        nbytes   <= 9'h000;
        mid_byte <= 1'b0;
      end
    end else if (rise) begin
      bitcnt   <= bitcnt + 3'h1;
      shreg    <= shifted;
      mid_byte <= (bitcnt != 3'h7);
      unique case (state)
        ST_OP: if (bitcnt == 3'h7) begin
          opcode    <= shifted;
          addr      <= 24'h000000;
          nbytes    <= 9'h000;
          phase_cnt <= 6'h00;
          if (has_addr) state <= ST_ADDR;
          else if (dummy_len != 6'h00) state <= ST_DUMMY;
          else if (is_read) state <= ST_OUT;
          else if (known_op(shifted)) state <= ST_DATA;
          else state <= ST_IGNORE;
        end
        ST_ADDR: begin
          addr      <= next_addr;
          phase_cnt <= phase_cnt + 6'h01;
          if (phase_cnt == sfc_pkg::N_ADDR - 6'h01) begin
            phase_cnt <= 6'h00;
            if (dummy_len_q != 6'h00) state <= ST_DUMMY;
            else if (read_q) state <= ST_OUT;
            else state <= ST_DATA;
          end
        end
        ST_DUMMY: begin
          phase_cnt <= phase_cnt + 6'h01;
          if (phase_cnt == dummy_len_q - 6'h01) state <= ST_OUT;
        end
        ST_DATA: if (bitcnt == 3'h7 && nbytes != sfc_pkg::PAGE_MAX) begin
          nbytes <= nbytes + 9'h001;
        end
        ST_OUT: begin
          // release opcode: count the id clocks
          if (phase_cnt != sfc_pkg::N_RDPD_ID) phase_cnt <= phase_cnt + 6'h01;
        end
        ST_IGNORE: begin
        end
      endcase
    end
  end

  // dummy length and read flag remembered for the later phases
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dummy_len_q <= 6'h00;
      read_q      <= 1'b0;
    end else if (rise && state == ST_OP && bitcnt == 3'h7) begin
      dummy_len_q <= dummy_len;
      read_q      <= is_read;
    end
  end

  // =====================================================================
  // read and data strobes toward the array side
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      read_start    <= 1'b0;
      read_opcode   <= 8'h00;
      read_addr     <= '0;
      read_active   <= 1'b0;
      data_valid    <= 1'b0;
      data_byte     <= 8'h00;
      id_out_active <= 1'b0;
    end else begin
      read_start <= rise && ((state == ST_OP && bitcnt == 3'h7 && is_read && !has_addr && dummy_len == 6'h00) ||
                   (state == ST_ADDR && phase_cnt == sfc_pkg::N_ADDR - 6'h01 && read_q && dummy_len_q == 6'h00) ||
                   (state == ST_DUMMY && phase_cnt == dummy_len_q - 6'h01));
      if (rise && state == ST_OP && bitcnt == 3'h7) read_opcode <= shifted;
      if (rise && state == ST_ADDR) read_addr <= next_addr[ADDR_BITS-1:0];
      read_active   <= cs_low && state == ST_OUT;
      id_out_active <= cs_low && state == ST_OUT && opcode == sfc_pkg::OP_RDPD &&
                       phase_cnt == sfc_pkg::N_RDPD_ID;
      data_valid    <= rise && state == ST_DATA && bitcnt == 3'h7 && nbytes != sfc_pkg::PAGE_MAX;
      if (rise && state == ST_DATA && bitcnt == 3'h7) data_byte <= shifted;
    end
  end

  // =====================================================================
  // commit on select rising
  logic       commit_ok;
  logic       wel_ok;
  logic [1:0] sec_idx;
  assign commit_ok = cs_rise && !mid_byte && state == ST_DATA;
  assign wel_ok    = write_latch_flag && !busy_flag;
  assign sec_idx   = addr[13:12] - 2'h1;

  logic wrsr_go;
  logic prog_go;
  logic erase_go;
  logic sec_ok;
  assign sec_ok   = (addr[13:12] != 2'h0) && !security_locks[sec_idx];
  assign wrsr_go  = commit_ok && wel_ok && nbytes != 9'h000 &&
                    (opcode == sfc_pkg::OP_WRSR1 || opcode == sfc_pkg::OP_WRSR2 || opcode == sfc_pkg::OP_WRSR3);
  assign prog_go  = commit_ok && wel_ok && nbytes != 9'h000 &&
                    (opcode == sfc_pkg::OP_PP || opcode == sfc_pkg::OP_QPP ||
                     (opcode == sfc_pkg::OP_PSR && sec_ok));
  assign erase_go = commit_ok && wel_ok &&
                    (opcode == sfc_pkg::OP_SE || opcode == sfc_pkg::OP_BE32 || opcode == sfc_pkg::OP_BE64 ||
                     opcode == sfc_pkg::OP_CE1 || opcode == sfc_pkg::OP_CE2 || (opcode == sfc_pkg::OP_ESR && sec_ok));

  // first and latest data bytes kept for status writes
  logic [15:0] wr_data;
  always_ff @(posedge ref_clk) begin
    if (reset) wr_data <= 16'h0000;
    else if (rise && state == ST_DATA && bitcnt == 3'h7) wr_data <= (nbytes == 9'h000) ? {shifted, 8'h00} :
                                                                      {wr_data[15:8], shifted};
  end

  // =====================================================================
  // non-volatile status bits
  logic [23:0] next_status;
  always_comb begin
    next_status = status;
    unique case (opcode)
      sfc_pkg::OP_WRSR1: begin
        next_status[7:2] = wr_data[15:10];
        if (nbytes == 9'h002) begin
          next_status[14:8]  = {wr_data[6], wr_data[5:3] | status[13:11], wr_data[2:0]};
          next_status[15]    = status[15];
          next_status[10]    = status[10];
        end
      end
      sfc_pkg::OP_WRSR2: next_status[14:11] = {wr_data[14], wr_data[13:11] | status[13:11]};
      sfc_pkg::OP_WRSR3: next_status[sfc_pkg::SB_DC] = wr_data[8];
      default: begin
      end
    endcase
  end

  // whole status word in one process; bits 1 and 0 mirror latch and busy
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status <= sfc_pkg::STATUS_RESET;
    end else begin
      if (wrsr_go) status[23:2] <= next_status[23:2];
      status[1:0] <= {write_latch_flag, busy_flag};
    end
  end

  // =====================================================================
  // write latch, busy and power state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      write_latch_flag <= 1'b0;
      busy_flag        <= 1'b0;
      deep_power_down  <= 1'b0;
    end else begin
      if (busy_flag && engine_done) begin
        busy_flag        <= 1'b0;
        write_latch_flag <= 1'b0;
      end else if (wrsr_go || prog_go || erase_go) begin
        busy_flag <= 1'b1;
      end else if (commit_ok && opcode == sfc_pkg::OP_WREN && !busy_flag) begin
        write_latch_flag <= 1'b1;
      end else if (commit_ok && opcode == sfc_pkg::OP_WRDI && !busy_flag) begin
        write_latch_flag <= 1'b0;
      end
      if (commit_ok && opcode == sfc_pkg::OP_DPD && !busy_flag) deep_power_down <= 1'b1;
      if (rise && state == ST_OP && bitcnt == 3'h7 && shifted == sfc_pkg::OP_RDPD) deep_power_down <= 1'b0;
    end
  end

  // command handed to the engine; partial bytes never reach here
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      exec_valid <= 1'b0;
      exec_cmd   <= '0;
    end else begin
      exec_valid <= wrsr_go || prog_go || erase_go;
      if (wrsr_go || prog_go || erase_go) begin
        exec_cmd.opcode <= opcode;
        exec_cmd.addr   <= addr;
        exec_cmd.nbytes <= nbytes;
        if (wrsr_go) exec_cmd.kind <= sfc_pkg::SFC_K_WRSR;
        else if (opcode == sfc_pkg::OP_PSR) exec_cmd.kind <= sfc_pkg::SFC_K_SEC_PROG;
        else if (opcode == sfc_pkg::OP_ESR) exec_cmd.kind <= sfc_pkg::SFC_K_SEC_ERASE;
        else if (prog_go) exec_cmd.kind <= sfc_pkg::SFC_K_PROG;
        else if (opcode == sfc_pkg::OP_CE1 || opcode == sfc_pkg::OP_CE2) exec_cmd.kind <= sfc_pkg::SFC_K_CHIP;
        else exec_cmd.kind <= sfc_pkg::SFC_K_ERASE;
      end
    end
  end

  // derived views of the status word
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      security_locks     <= 3'h0;
      protect_complement <= 1'b0;
      dummy_cycle_select <= 1'b0;
    end else begin
      security_locks     <= status[sfc_pkg::SB_LOCK3:sfc_pkg::SB_LOCK1];
      protect_complement <= status[sfc_pkg::SB_CMP];
      dummy_cycle_select <= status[sfc_pkg::SB_DC];
    end
  end
endmodule

/* tb/sfc_frontend_bench.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); \
  end \
end
// ====================================
// bench for the command front end
module sfc_frontend_bench;
  logic                    ref_clk, reset, engine_done;
  wire                     exec_valid, data_valid, read_start, read_active, id_out_active;
  wire                     deep_power_down, write_latch_flag, busy_flag, protect_complement;
  wire                     dummy_cycle_select, select_n, serial_clk, serial_in;
  wire [2:0]               security_locks;
  wire [7:0]               data_byte, read_opcode;
  wire [23:0]              status, read_addr;
  wire sfc_pkg::sfc_exec_t exec_cmd;
  logic [7:0]              last_byte, last_rop;
  sfc_pkg::sfc_exec_t      last_exec;
  int n_errors, total_checks, n_exec, exp_exec, start_at;
  logic [7:0] erase_ops [5] = '{sfc_pkg::OP_SE, sfc_pkg::OP_BE32, sfc_pkg::OP_BE64,
                                sfc_pkg::OP_CE1, sfc_pkg::OP_CE2};
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;
  sfc_host_model host_u (.ref_clk(ref_clk), .select_n(select_n), .serial_clk(serial_clk),
    .serial_in(serial_in));
  sfc_frontend dut_u (
    .ref_clk(ref_clk), .reset(reset), .select_n(select_n), .serial_clk(serial_clk),
    .serial_in(serial_in), .engine_done(engine_done), .exec_valid(exec_valid), .exec_cmd(exec_cmd),
    .data_valid(data_valid), .data_byte(data_byte), .read_start(read_start), .read_opcode(read_opcode),
    .read_addr(read_addr), .read_active(read_active), .id_out_active(id_out_active),
    .deep_power_down(deep_power_down), .status(status), .write_latch_flag(write_latch_flag),
    .busy_flag(busy_flag), .security_locks(security_locks), .protect_complement(protect_complement),
    .dummy_cycle_select(dummy_cycle_select));
  // record commits, data bytes and read starts
  always @(posedge ref_clk) begin
    if (exec_valid === 1'b1) begin
      n_exec++;
      last_exec = exec_cmd;
    end
    if (data_valid === 1'b1) last_byte = data_byte;
    if (read_start === 1'b1) begin
      start_at = host_u.rises;
      last_rop = read_opcode;
    end
  end
  task automatic tx_addr(input logic [23:0] a);
    host_u.tx_byte(a[23:16]);
    host_u.tx_byte(a[15:8]);
    host_u.tx_byte(a[7:0]);
  endtask
  task automatic one_op(input logic [7:0] op);
    host_u.open_frame();
    host_u.tx_byte(op);
    host_u.close_frame();
  endtask
  // one commit expected; engine then finishes it
  task automatic retire();
    exp_exec++;
    `CHK(n_exec, exp_exec)
    `CHK(busy_flag, 1'b1)
    @(negedge ref_clk);
    engine_done = 1'b1;
    @(negedge ref_clk);
    engine_done = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK(busy_flag, 1'b0)
    `CHK(write_latch_flag, 1'b0)
  endtask
  // read: count rises before the output phase starts
  task automatic probe(input logic [7:0] op, input int exp);
    start_at = 0;
    host_u.open_frame();
    host_u.tx_byte(op);
    tx_addr(24'h5A3C96);
    repeat (16) host_u.tx_bit(1'b0);
    `CHK(start_at, exp)
    `CHK(last_rop, op)
    `CHK(read_active, 1'b1)
    host_u.close_frame();
    `CHK(read_active, 1'b0)
  endtask
  task automatic finish_test();
    $display("checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // about 9k cycles needed; 1 ms is ample
  initial begin
    #1000000;
    n_errors++;
    finish_test();
  end
  // main sequence
  initial begin
    reset = 1'b1;
    engine_done = 1'b0;
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK(status, sfc_pkg::STATUS_RESET)
    `CHK({protect_complement, dummy_cycle_select, security_locks}, 5'h00)
    // program without latch is refused
    host_u.open_frame();
    host_u.tx_byte(sfc_pkg::OP_PP);
    tx_addr(24'h000100);
    host_u.tx_byte(8'hA5);
    host_u.close_frame();
    `CHK(n_exec, exp_exec)
    one_op(sfc_pkg::OP_WREN);
    `CHK(write_latch_flag, 1'b1)
    one_op(sfc_pkg::OP_WRDI);
    `CHK(write_latch_flag, 1'b0)
    // program cut three bits into a byte
    one_op(sfc_pkg::OP_WREN);
    host_u.open_frame();
    host_u.tx_byte(sfc_pkg::OP_PP);
    tx_addr(24'h000200);
    host_u.tx_byte(8'h3C);
    repeat (3) host_u.tx_bit(1'b1);
    host_u.close_frame();
    `CHK(n_exec, exp_exec)
    `CHK(write_latch_flag, 1'b1)
    // whole two-byte program, latch still set
    host_u.open_frame();
    host_u.tx_byte(sfc_pkg::OP_PP);
    tx_addr(24'h012345);
    host_u.tx_byte(8'hC3);
    host_u.tx_byte(8'h5A);
    host_u.close_frame();
    `CHK(last_exec.kind, sfc_pkg::SFC_K_PROG)
    `CHK(last_exec.addr, 24'h012345)
    `CHK(last_exec.nbytes, 9'h002)
    `CHK(last_byte, 8'h5A)
    retire();
    // every erase opcode except the security register erase
    for (int i = 0; i < 5; i++) begin
      one_op(sfc_pkg::OP_WREN);
      host_u.open_frame();
      host_u.tx_byte(erase_ops[i]);
      if (i < 3) tx_addr(24'h0A0000);
      host_u.close_frame();
      `CHK(last_exec.opcode, erase_ops[i])
      `CHK(last_exec.kind, (i < 3) ? sfc_pkg::SFC_K_ERASE : sfc_pkg::SFC_K_CHIP)
      retire();
    end
    // status write sets lock one and complement
    one_op(sfc_pkg::OP_WREN);
    host_u.open_frame();
    host_u.tx_byte(sfc_pkg::OP_WRSR1);
    host_u.tx_byte(8'h00);
    host_u.tx_byte(8'h48);
    host_u.close_frame();
    retire();
    `CHK(security_locks, 3'h1)
    `CHK(protect_complement, 1'b1)
    // writing zeros leaves the lock set
    one_op(sfc_pkg::OP_WREN);
    host_u.open_frame();
    host_u.tx_byte(sfc_pkg::OP_WRSR2);
    host_u.tx_byte(8'h00);
    host_u.close_frame();
    retire();
    `CHK(security_locks, 3'h1)
    `CHK(protect_complement, 1'b0)
    // locked security register refuses program
    one_op(sfc_pkg::OP_WREN);
    host_u.open_frame();
    host_u.tx_byte(sfc_pkg::OP_PSR);
    tx_addr(24'h001000);
    host_u.tx_byte(8'h11);
    host_u.close_frame();
    `CHK(n_exec, exp_exec)
    // unknown opcode with trailing bytes does nothing
    one_op(sfc_pkg::OP_WREN);
    host_u.open_frame();
    host_u.tx_byte(8'hFF);
    host_u.tx_byte(sfc_pkg::OP_PP);
    tx_addr(24'h000000);
    host_u.close_frame();
    `CHK(n_exec, exp_exec)
    `CHK(write_latch_flag, 1'b1)
    // read start points, short dummy setting
    probe(sfc_pkg::OP_DOREAD, 40);
    `CHK(read_addr, 24'h5A3C96)
    probe(sfc_pkg::OP_RDSR1, 8);
    probe(sfc_pkg::OP_QOREAD, 40);
    probe(sfc_pkg::OP_DIOREAD, 36);
    probe(sfc_pkg::OP_QIOREAD, 38);
    probe(sfc_pkg::OP_UID, 40);
    probe(sfc_pkg::OP_READ, 32);
    probe(sfc_pkg::OP_FREAD, 40);
    // long dummy setting
    host_u.open_frame();
    host_u.tx_byte(sfc_pkg::OP_WRSR3);
    host_u.tx_byte(8'h01);
    host_u.close_frame();
    retire();
    `CHK(dummy_cycle_select, 1'b1)
    probe(sfc_pkg::OP_DIOREAD, 40);
    probe(sfc_pkg::OP_QIOREAD, 42);
    // power down: one stray bit cancels it
    host_u.open_frame();
    host_u.tx_byte(sfc_pkg::OP_DPD);
    host_u.tx_bit(1'b0);
    host_u.close_frame();
    `CHK(deep_power_down, 1'b0)
    one_op(sfc_pkg::OP_DPD);
    `CHK(deep_power_down, 1'b1)
    one_op(sfc_pkg::OP_RDPD);
    `CHK(deep_power_down, 1'b0)
    host_u.open_frame();
    host_u.tx_byte(sfc_pkg::OP_RDPD);
    repeat (25) host_u.tx_bit(1'b0);
    `CHK(id_out_active, 1'b1)
    host_u.close_frame();
    finish_test();
  end
endmodule

/* tb/sfc_frontend_properties.sv */
`timescale 1ns/10ps
// ====================================
// port checker for the command front end
module sfc_frontend_properties (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        select_n,
  input wire logic        engine_done,
  input wire logic        exec_valid,
  input wire logic        read_start,
  input wire logic        read_active,
  input wire logic [23:0] status,
  input wire logic        write_latch_flag,
  input wire logic        busy_flag,
  input wire logic [2:0]  security_locks,
  input wire logic        protect_complement,
  input wire logic        dummy_cycle_select
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // config outputs follow the status word one cycle later, locks only ever set
  property p_locks; security_locks == $past(status[13:11]); endproperty
  a_locks: assert property (p_locks)
    else $error("lock outputs differ from status");
  property p_sticky; (security_locks & $past(security_locks)) == $past(security_locks); endproperty
  a_sticky: assert property (p_sticky)
    else $error("a lock bit cleared");
  property p_cmp; protect_complement == $past(status[14]); endproperty
  a_cmp: assert property (p_cmp)
    else $error("complement differs from status");
  property p_dc; dummy_cycle_select == $past(status[16]); endproperty
  a_dc: assert property (p_dc)
    else $error("dummy select differs from status");
  // commits need the latch and a finished frame
  property p_latch; exec_valid |-> write_latch_flag; endproperty
  a_latch: assert property (p_latch)
    else $error("commit without latch");
  property p_frame_end; exec_valid |-> $past(select_n, 2); endproperty
  a_frame_end: assert property (p_frame_end)
    else $error("commit inside a frame");
  // busy follows a commit and holds until the engine is done
  property p_busy_on; exec_valid |-> ##[0:2] busy_flag; endproperty
  a_busy_on: assert property (p_busy_on)
    else $error("busy not raised after commit");
  property p_busy_hold; busy_flag && !engine_done |=> busy_flag; endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped early");
  // output phase starts with read_start and ends on deselect
  property p_rd_on; read_start |-> ##[0:1] read_active; endproperty
  a_rd_on: assert property (p_rd_on)
    else $error("read phase not active");
  property p_rd_off; select_n [*6] |-> !read_active; endproperty
  a_rd_off: assert property (p_rd_off)
    else $error("read phase outlived select");
  c_exec: cover property (exec_valid);
  c_read: cover property (read_start);
  c_lock: cover property ($rose(security_locks[0]));
endmodule
bind sfc_frontend sfc_frontend_properties chk_u (
  .ref_clk(ref_clk), .reset(reset), .select_n(select_n), .engine_done(engine_done),
  .exec_valid(exec_valid), .read_start(read_start), .read_active(read_active), .status(status),
  .write_latch_flag(write_latch_flag), .busy_flag(busy_flag), .security_locks(security_locks),
  .protect_complement(protect_complement), .dummy_cycle_select(dummy_cycle_select));

/* tb/sfc_host_model.sv */
`timescale 1ns/10ps
// ====================================
// spi host, clock parked low between frames
module sfc_host_model (
  input wire logic ref_clk,
  output logic     select_n,
  output logic     serial_clk,
  output logic     serial_in
);
  int rises;
  initial begin
    select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b1;
    rises = 0;
  end
  // half serial period, 4 ref_clk cycles; serial clock runs at ref_clk/8
  task automatic half();
    repeat (4) @(negedge ref_clk);
  endtask
  // data set while clock low, taken on the rise
  task automatic tx_bit(input logic b);
    serial_in = b;
    half();
    serial_clk = 1'b1;
    rises++;
    half();
    serial_clk = 1'b0;
  endtask
  task automatic tx_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      tx_bit(b[i]);
    end
  endtask
  task automatic open_frame();
    @(negedge ref_clk);
    select_n = 1'b0;
    rises = 0;
    half();
  endtask
  // deselect after the last fall; idle data line toggled
  task automatic close_frame();
    half();
    select_n = 1'b1;
    serial_in = ~serial_in;
    repeat (12) @(negedge ref_clk);
  endtask
endmodule
